/* ahb_reg_port.sv */
// AHB-Lite slave front end, zero wait states
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  reg_access_if.port       ra
);
  logic       req;
  logic       wpend_r;
  logic [7:0] waddr_r;

  // Reads sample in the address phase so the data phase needs no wait state
  assign req       = hsel_i && hready_i && htrans_i[1];
  assign ra.rd_en  = req && !hwrite_i;
  assign ra.wr_en  = wpend_r;
  // Separate write address: a read address phase may overlap a write data phase
  assign ra.addr   = haddr_i[7:0];
  assign ra.waddr  = waddr_r;
  assign ra.wdata  = hwdata_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wpend_r <= 1'b0;
      waddr_r <= 8'h00;
    end
    else if (hready_i)
    begin
      wpend_r <= req && hwrite_i && (haddr_i[31:8] == 24'h00_0000);
      waddr_r <= haddr_i[7:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hrdata_o <= 32'h0000_0000;
    else if (ra.rd_en)
      hrdata_o <= (haddr_i[31:8] == 24'h00_0000) ? ra.rdata : 32'h0000_0000;
  end
endmodule // ahb_reg_port
`default_nettype wire

/* host_mcu_model.sv */
// Host processor model: AHB-Lite single-word master that services the flag registers
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model
(
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  input  wire logic [31:0] rdata_i,
  output logic             sel_o,
  output logic [31:0]      addr_o,
  output logic [1:0]       trans_o,
  output logic             write_o,
  output logic [31:0]      wdata_o
);
  initial
  begin
    sel_o   = 1'b1;
    addr_o  = 32'h0000_0000;
    trans_o = 2'b00;
    write_o = 1'b0;
    wdata_o = 32'h0000_0000;
  end

  // One transfer; waits on ready with no assumed latency
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    trans_o <= 2'b10;
    addr_o  <= a;
    write_o <= wr;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    trans_o <= 2'b00;
    addr_o  <= ~a;
    wdata_o <= d; // Flags are only dropped by writing ones back
    do @(posedge clk_i); while (ready_i !== 1'b1);
    q = rdata_i;
    // Released data lines must not keep a plausible value
    wdata_o <= ~d;
  endtask
endmodule // host_mcu_model
`default_nettype wire

/* power_event_map.svh */
// Register offsets, field positions, reset values and timing for the power event unit
`ifndef POWER_EVENT_MAP_SVH
`define POWER_EVENT_MAP_SVH
`define OFS_FLAG        8'h00
`define OFS_MASK        8'h04
`define OFS_LIVE        8'h08
`define OFS_CFG         8'h0C
`define OFS_STAT        8'h10
`define NFLAG           8
`define FB_WD           0
`define FB_ENA          1
`define FB_SEQ          2
`define FB_INST         3
`define FB_MCU          4
`define FB_SOC          5
`define FB_OVP          6
`define FB_SEV          7
`define MASKABLE        8'h3E
`define MASK_RST        8'h00
`define CFG_LPSEL       0
`define CFG_PD          1
`define CFG_LIM_LO      2
`define CFG_TGT_LO      6
`define CFG_RESP_LO     8
`define CFG_RST         32'h0000_FF02
`define RECOV_MAX       4'hF
`define CLK_MHZ         250
`define WARM_RESET_NS   1000
`endif

/* power_event_pkg.sv */
// Types shared by the power event unit
package power_event_pkg;
  typedef enum {W_IDLE, W_HOLD} warm_state_e;
  typedef logic [7:0] flag_t;
endpackage

/* power_event_response_unit.sv */
// Event response, recovery and interrupt flags of the power manager
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`include "power_event_map.svh"
`timescale 1ns/1ps
`default_nettype none
module power_event_response_unit
(
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RST_I,
  input  wire logic                        HSEL_I,
  input  wire logic [31:0]                 HADDR_I,
  input  wire logic [1:0]                  HTRANS_I,
  input  wire logic                        HWRITE_I,
  input  wire logic [2:0]                  HSIZE_I,
  input  wire logic                        HREADY_I,
  input  wire logic [31:0]                 HWDATA_I,
  output logic      [31:0]                 HRDATA_O,
  output logic                             HREADYOUT_O,
  output logic                             HRESP_O,
  input  wire logic                        WD_LONG_WINDOW_TIMEOUT_I,
  input  wire logic                        ENABLE_PIN_I,
  input  wire logic                        SEQ_OFF_FAULT_I,
  input  wire logic                        INSTANT_OFF_FAULT_I,
  input  wire logic                        MCU_SUPPLY_ERR_I,
  input  wire logic                        SOC_SUPPLY_ERR_I,
  input  wire logic                        INPUT_OVERVOLTAGE_I,
  input  wire logic [1:0]                  CURRENT_STATE_I,
  output logic                             DRIVER_ENABLE_O,
  output logic                             MCU_RESET_N_O,
  output logic                             SOC_RESET_N_O,
  output logic                             WATCHDOG_RESET_TRIGGER_O,
  output logic                             RESUME_TRIGGER_O,
  output logic      [1:0]                  RESUME_STATE_O,
  output logic                             FORCE_STANDBY_TRIGGER_O,
  output logic                             FORCE_LOW_POWER_IDLE_TRIGGER_O,
  output logic                             STARTUP_TRIGGER_O,
  output logic      [1:0]                  STARTUP_TARGET_STATE_O,
  output logic                             SEQUENCED_OFF_TRIGGER_O,
  output logic                             INSTANT_OFF_TRIGGER_O,
  output logic                             MCU_POWER_ERR_TRIGGER_O,
  output logic                             SOC_POWER_ERR_TRIGGER_O,
  output logic                             REGULATORS_OFF_O,
  output logic                             GPIO_LOW_SEQUENCED_O,
  output logic                             GPIO_LOW_IMMEDIATE_O,
  output logic                             PULLDOWN_EN_O,
  output logic                             SAFE_HOLD_STATE_O,
  output logic                             IRQ_O,
  output power_event_pkg::flag_t           FLAG_O
);
  import power_event_pkg::*;

  localparam int WARM_CYC = (`WARM_RESET_NS * `CLK_MHZ + 999) / 1000;

  reg_access_if ra ();

  warm_state_e warm_r;
  logic [8:0]  warm_cnt_r;
  flag_t       flag_r;
  flag_t       mask_r;
  flag_t       set_vec;
  flag_t       hold_vec;
  flag_t       clr_vec;
  flag_t       vis_vec;
  flag_t       resp;
  logic [31:0] cfg_r;
  logic [3:0]  recov_r;
  logic [3:0]  limit;
  logic        halt_r;
  logic        off_r;
  logic        en_q_r;
  logic [5:0]  fault_q_r;
  logic [5:0]  fault_now;
  logic [5:0]  fault_rise;
  logic        en_rise;
  logic        warm_go;
  logic        warm_done;
  logic        restart_go;
  logic        recov_inc;
  logic        any_fault;
  logic        wd_visible;

  ahb_reg_port u_port
  (
    .clk_i    (CORE_CLK_I),
    .rst_i    (RST_I),
    .hsel_i   (HSEL_I),
    .haddr_i  (HADDR_I),
    .htrans_i (HTRANS_I),
    .hwrite_i (HWRITE_I),
    .hready_i (HREADY_I),
    .hwdata_i (HWDATA_I),
    .hrdata_o (HRDATA_O),
    .ra       (ra.port)
  );

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  // Per-event default responses can be disabled from configuration
  assign resp  = cfg_r[`CFG_RESP_LO +: 8];
  assign limit = cfg_r[`CFG_LIM_LO +: 4];

  assign fault_now  = {INPUT_OVERVOLTAGE_I, SOC_SUPPLY_ERR_I, MCU_SUPPLY_ERR_I,
                       INSTANT_OFF_FAULT_I, SEQ_OFF_FAULT_I, WD_LONG_WINDOW_TIMEOUT_I};
  assign fault_rise = fault_now & ~fault_q_r;
  assign en_rise    = ENABLE_PIN_I && !en_q_r;
  assign any_fault  = |fault_now[5:1];

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      en_q_r    <= 1'b1;
      fault_q_r <= 6'h00;
    end
    else
    begin
      en_q_r    <= ENABLE_PIN_I;
      fault_q_r <= fault_now;
    end
  end

  // Warm reset sequence
  assign warm_go   = fault_rise[0] && (warm_r == W_IDLE) && resp[`FB_WD];
  assign warm_done = (warm_r == W_HOLD) && (warm_cnt_r == 9'd1);

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      warm_r     <= W_IDLE;
      warm_cnt_r <= 9'd0;
    end
    else
    begin
      case (warm_r)
        W_IDLE:
        begin
          if (warm_go)
          begin
            warm_r     <= W_HOLD;
            warm_cnt_r <= 9'(WARM_CYC);
          end
        end
        W_HOLD:
        begin
          warm_cnt_r <= warm_cnt_r - 9'd1;
          if (warm_done)
            warm_r <= W_IDLE;
        end
        default:
          warm_r <= W_IDLE;
      endcase
    end
  end

  // Driver enable stays low and both resets pulse for the whole hold
  assign DRIVER_ENABLE_O = (warm_r == W_IDLE);
  assign MCU_RESET_N_O   = (warm_r == W_IDLE);
  assign SOC_RESET_N_O   = (warm_r == W_IDLE);

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      WATCHDOG_RESET_TRIGGER_O <= 1'b0;
      RESUME_TRIGGER_O         <= 1'b0;
      RESUME_STATE_O           <= 2'b00;
    end
    else
    begin
      WATCHDOG_RESET_TRIGGER_O <= warm_go;
      RESUME_TRIGGER_O         <= warm_done;
      if (warm_go)
        RESUME_STATE_O <= CURRENT_STATE_I;
    end
  end

  // Recovery count and limit; the limit is only lifted by a power cycle
  assign restart_go = off_r && !any_fault && !halt_r && (warm_r == W_IDLE);
  assign recov_inc  = warm_done || restart_go;

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      recov_r <= 4'h0;
    else if (recov_inc && recov_r != `RECOV_MAX)
      recov_r <= recov_r + 4'h1;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      halt_r <= 1'b0;
    else if (limit != 4'h0 && recov_r > limit)
      halt_r <= 1'b1;
  end

  // Shutdown state and automatic restart to the start-up target
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      off_r                <= 1'b0;
      GPIO_LOW_SEQUENCED_O <= 1'b0;
      GPIO_LOW_IMMEDIATE_O <= 1'b0;
      PULLDOWN_EN_O        <= 1'b0;
    end
    else if ((fault_rise[1] && resp[`FB_SEQ]) || (halt_r && !off_r))
    begin
      off_r                <= 1'b1;
      GPIO_LOW_SEQUENCED_O <= 1'b1;
    end
    else if ((fault_rise[2] && resp[`FB_INST]) || (fault_rise[5] && resp[`FB_OVP]))
    begin
      off_r                <= 1'b1;
      GPIO_LOW_IMMEDIATE_O <= 1'b1;
      PULLDOWN_EN_O        <= fault_rise[5] || cfg_r[`CFG_PD];
    end
    else if (restart_go)
    begin
      off_r                <= 1'b0;
      GPIO_LOW_SEQUENCED_O <= 1'b0;
      GPIO_LOW_IMMEDIATE_O <= 1'b0;
      PULLDOWN_EN_O        <= 1'b0;
    end
  end

  assign REGULATORS_OFF_O       = off_r;
  assign SAFE_HOLD_STATE_O      = INPUT_OVERVOLTAGE_I && off_r;
  assign STARTUP_TARGET_STATE_O = cfg_r[`CFG_TGT_LO +: 2];

  // Enable low is a level request for as long as the pin is low
  assign FORCE_STANDBY_TRIGGER_O        = !ENABLE_PIN_I && !cfg_r[`CFG_LPSEL];
  assign FORCE_LOW_POWER_IDLE_TRIGGER_O = !ENABLE_PIN_I && cfg_r[`CFG_LPSEL];

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      STARTUP_TRIGGER_O       <= 1'b0;
      SEQUENCED_OFF_TRIGGER_O <= 1'b0;
      INSTANT_OFF_TRIGGER_O   <= 1'b0;
      MCU_POWER_ERR_TRIGGER_O <= 1'b0;
      SOC_POWER_ERR_TRIGGER_O <= 1'b0;
    end
    else
    begin
      STARTUP_TRIGGER_O       <= (en_rise && resp[`FB_ENA]) || restart_go;
      SEQUENCED_OFF_TRIGGER_O <= fault_rise[1] && resp[`FB_SEQ];
      INSTANT_OFF_TRIGGER_O   <= (fault_rise[2] && resp[`FB_INST]) || (fault_rise[5] && resp[`FB_OVP]);
      MCU_POWER_ERR_TRIGGER_O <= fault_rise[3] && resp[`FB_MCU];
      SOC_POWER_ERR_TRIGGER_O <= fault_rise[4] && resp[`FB_SOC];
    end
  end

  // Flag bank: set wins over a write-one clear
  assign set_vec  = {fault_rise[5], fault_rise[5], fault_rise[4], fault_rise[3],
                     fault_rise[2], fault_rise[1], en_rise, fault_rise[0]};
  assign hold_vec = {INPUT_OVERVOLTAGE_I, INPUT_OVERVOLTAGE_I, SOC_SUPPLY_ERR_I,
                     MCU_SUPPLY_ERR_I, INSTANT_OFF_FAULT_I, SEQ_OFF_FAULT_I, 1'b0, !wd_visible};
  assign wd_visible = (warm_r == W_IDLE) && !halt_r;
  assign clr_vec  = (ra.wr_en && ra.waddr == `OFS_FLAG) ? ra.wdata[7:0] : 8'h00;
  assign vis_vec  = {{2{!INPUT_OVERVOLTAGE_I}}, 5'h1F, wd_visible};

  for (genvar b = 0; b < `NFLAG; b++)
  begin : g_flag
    always_ff @(posedge CORE_CLK_I)
    begin
      if (RST_I)
        flag_r[b] <= 1'b0;
      else if (set_vec[b])
        flag_r[b] <= 1'b1;
      else if (clr_vec[b] && !hold_vec[b])
        flag_r[b] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      mask_r <= `MASK_RST;
      cfg_r  <= `CFG_RST;
    end
    else if (ra.wr_en && ra.waddr == `OFS_MASK)
      mask_r <= ra.wdata[7:0] & `MASKABLE;
    else if (ra.wr_en && ra.waddr == `OFS_CFG)
      cfg_r  <= {16'h0000, ra.wdata[15:0]};
  end

  // Long-window, overvoltage and severe flags cannot be masked
  assign IRQ_O  = |(flag_r & vis_vec & ~mask_r);
  assign FLAG_O = flag_r;

  always_comb
  begin
    case (ra.addr)
      `OFS_FLAG: ra.rdata = {24'h00_0000, flag_r & vis_vec};
      `OFS_MASK: ra.rdata = {24'h00_0000, mask_r};
      `OFS_LIVE: ra.rdata = {24'h00_0000, INPUT_OVERVOLTAGE_I, 6'h00, ENABLE_PIN_I};
      `OFS_CFG:  ra.rdata = cfg_r;
      `OFS_STAT: ra.rdata = {24'h00_0000, SAFE_HOLD_STATE_O, off_r, halt_r, warm_r == W_HOLD, recov_r};
      default:   ra.rdata = 32'h0000_0000;
    endcase
  end

  chk_wd_warm_entry: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    warm_go |=> (!DRIVER_ENABLE_O && !MCU_RESET_N_O && !SOC_RESET_N_O && flag_r[0]))
    else $error("warm reset not entered");
  chk_warm_resume: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    $rose(DRIVER_ENABLE_O) |-> RESUME_TRIGGER_O)
    else $error("no resume after warm reset");
  chk_wd_clear: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (clr_vec[0] && wd_visible && !set_vec[0]) |=> !flag_r[0])
    else $error("long-window flag not cleared");
  chk_wd_hidden: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (warm_r == W_HOLD && ra.addr == `OFS_FLAG) |-> !ra.rdata[0])
    else $error("long-window flag visible during warm reset");
  chk_enable_force: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    !ENABLE_PIN_I |-> (FORCE_STANDBY_TRIGGER_O ^ FORCE_LOW_POWER_IDLE_TRIGGER_O))
    else $error("enable low not forcing idle");
  chk_enable_rise: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (en_rise && resp[`FB_ENA]) |=> (STARTUP_TRIGGER_O && flag_r[`FB_ENA]))
    else $error("enable rise not handled");
  chk_ovp_irq: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (flag_r[`FB_OVP] && !INPUT_OVERVOLTAGE_I) |-> IRQ_O)
    else $error("overvoltage flag masked");
  chk_recov_sat: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (recov_r == `RECOV_MAX) |=> (recov_r == `RECOV_MAX))
    else $error("recovery count wrapped");
  chk_hold_clear: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (flag_r[`FB_SEQ] && SEQ_OFF_FAULT_I) |=> flag_r[`FB_SEQ])
    else $error("flag cleared while fault present");
endmodule // power_event_response_unit
`default_nettype wire

/* power_event_response_unit_test.sv */
// Self-checking testbench for the power event response unit
`timescale 1ns/1ps
`default_nettype none
`include "power_event_map.svh"
module power_event_response_unit_test;
  import power_event_pkg::*;
  localparam logic [31:0] A_FLAG = 32'(`OFS_FLAG);
  localparam logic [31:0] A_MASK = 32'(`OFS_MASK);
  localparam logic [31:0] A_LIVE = 32'(`OFS_LIVE);
  localparam logic [31:0] A_CFG  = 32'(`OFS_CFG);
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  ev = 7'h02;
  logic [1:0]  cur_state = 2'h0;
  logic        hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, res_state, tgt;
  logic        drv_en, mrst_n, srst_n, f_stby, f_lpi, reg_off, gpio_seq, gpio_imm, pd_en, safe, irq;
  wire  [6:0]  trg;
  flag_t       flag;
  int          fails = 0;
  int          n_tests = 0;

  always #2 clk = ~clk;

  host_mcu_model u_host (.clk_i(clk), .ready_i(hready), .rdata_i(hrdata), .sel_o(hsel), .addr_o(haddr),
    .trans_o(htrans), .write_o(hwrite), .wdata_o(hwdata));

  power_event_response_unit u_dut (.CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HREADY_I(hready), .HWDATA_I(hwdata),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .WD_LONG_WINDOW_TIMEOUT_I(ev[0]),
    .ENABLE_PIN_I(ev[1]), .SEQ_OFF_FAULT_I(ev[2]), .INSTANT_OFF_FAULT_I(ev[3]), .MCU_SUPPLY_ERR_I(ev[4]),
    .SOC_SUPPLY_ERR_I(ev[5]), .INPUT_OVERVOLTAGE_I(ev[6]), .CURRENT_STATE_I(cur_state),
    .DRIVER_ENABLE_O(drv_en), .MCU_RESET_N_O(mrst_n), .SOC_RESET_N_O(srst_n),
    .WATCHDOG_RESET_TRIGGER_O(trg[0]), .RESUME_TRIGGER_O(trg[6]), .RESUME_STATE_O(res_state),
    .FORCE_STANDBY_TRIGGER_O(f_stby), .FORCE_LOW_POWER_IDLE_TRIGGER_O(f_lpi), .STARTUP_TRIGGER_O(trg[1]),
    .STARTUP_TARGET_STATE_O(tgt), .SEQUENCED_OFF_TRIGGER_O(trg[2]), .INSTANT_OFF_TRIGGER_O(trg[3]),
    .MCU_POWER_ERR_TRIGGER_O(trg[4]), .SOC_POWER_ERR_TRIGGER_O(trg[5]), .REGULATORS_OFF_O(reg_off),
    .GPIO_LOW_SEQUENCED_O(gpio_seq), .GPIO_LOW_IMMEDIATE_O(gpio_imm), .PULLDOWN_EN_O(pd_en),
    .SAFE_HOLD_STATE_O(safe), .IRQ_O(irq), .FLAG_O(flag));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0000_0000, q);
    check(q & m, exp, msg);
  endtask

  task automatic set_ev(input int i, input logic v);
    @(posedge clk);
    ev[i] <= v;
  endtask

  // Trigger must appear within a few cycles and last exactly one
  task automatic wait_trg(input int i);
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (trg[i] !== 1'b1 && k < 5);
    check(trg[i], 1, "trigger missing");
    @(posedge clk);
    #1;
    check(trg[i], 0, "trigger longer than one cycle");
  endtask

  task automatic t_reset;
    rdc(A_FLAG, 32'hFFFF_FFFF, 32'h0000_0000, "flag reset");
    rdc(A_MASK, 32'hFFFF_FFFF, 32'h0000_0000, "mask reset");
    rdc(A_CFG, 32'hFFFF_FFFF, `CFG_RST, "config reset");
    wr(32'h0000_0020, 32'hFFFF_FFFF);
    rdc(32'h0000_0020, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    check({irq, hresp, drv_en, tgt}, 32'h4, "idle outputs");
  endtask

  task automatic t_enable;
    set_ev(1, 1'b0);
    repeat (3) @(posedge clk);
    check({f_stby, f_lpi}, 32'h2, "standby forced");
    wr(A_CFG, 32'h0000_FFC3);
    #1;
    check({f_stby, f_lpi, tgt}, 32'h7, "low-power idle forced");
    rdc(A_LIVE, 32'h0000_0001, 32'h0000_0000, "enable live low");
    rdc(A_FLAG, 32'hFFFF_FFFF, 32'h0000_0000, "no flag while low");
    set_ev(1, 1'b1);
    wait_trg(1);
    wr(A_FLAG, 32'h0000_0000);
    rdc(A_FLAG, 32'hFFFF_FFFF, 32'h0000_0002, "enable flag kept");
    check(irq, 1, "irq on enable flag");
    wr(A_FLAG, 32'h0000_0002);
    rdc(A_FLAG, 32'hFFFF_FFFF, 32'h0000_0000, "enable flag cleared");
    wr(A_CFG, `CFG_RST);
  endtask

  task automatic t_seq;
    set_ev(2, 1'b1);
    wait_trg(2);
    check({reg_off, gpio_seq}, 32'h3, "sequenced off");
    wr(A_FLAG, 32'h0000_0004);
    rdc(A_FLAG, 32'h0000_0004, 32'h0000_0004, "clear refused while fault");
    set_ev(2, 1'b0);
    wait_trg(1);
    check(reg_off, 0, "regulators back");
    wr(A_FLAG, 32'h0000_0004);
    rdc(A_FLAG, 32'hFFFF_FFFF, 32'h0000_0000, "sequenced flag cleared");
  endtask

  task automatic t_inst;
    for (int p = 1; p >= 0; p--)
    begin
      wr(A_CFG, 32'h0000_FF00 | 32'(p << 1));
      set_ev(3, 1'b1);
      wait_trg(3);
      check({gpio_imm, reg_off, pd_en}, 32'(6 + p), "instant off");
      set_ev(3, 1'b0);
      wait_trg(1);
      wr(A_FLAG, 32'h0000_0008);
      rdc(A_FLAG, 32'hFFFF_FFFF, 32'h0000_0000, "instant flag cleared");
    end
    wr(A_CFG, `CFG_RST);
  endtask

  task automatic t_supply;
    wr(A_CFG, 32'h0000_EF02);
    set_ev(4, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    check({trg[4], flag[4]}, 32'h1, "response disabled, flag kept");
    set_ev(4, 1'b0);
    wr(A_FLAG, 32'h0000_0010);
    wr(A_CFG, `CFG_RST);
    for (int i = 4; i <= 5; i++)
    begin
      wr(A_MASK, 32'(1 << i));
      set_ev(i, 1'b1);
      wait_trg(i);
      check({flag[i], irq}, 32'h2, "masked supply flag");
      wr(A_MASK, 32'h0000_0000);
      #1;
      check(irq, 1, "unmasked supply flag");
      set_ev(i, 1'b0);
      wr(A_FLAG, 32'(1 << i));
      #1;
      check({flag, irq}, 32'h0, "supply flag cleared");
    end
  endtask

  task automatic t_ovp;
    wr(A_MASK, 32'h0000_003E);
    set_ev(6, 1'b1);
    repeat (3) @(posedge clk);
    check({safe, reg_off, pd_en}, 32'h7, "overvoltage shutdown");
    rdc(A_LIVE, 32'h0000_0080, 32'h0000_0080, "overvoltage live");
    rdc(A_FLAG, 32'h0000_0040, 32'h0000_0000, "overvoltage flag hidden");
    wr(A_FLAG, 32'h0000_00C0);
    set_ev(6, 1'b0);
    wait_trg(1);
    check({safe, irq}, 32'h1, "unmaskable irq");
    rdc(A_FLAG, 32'h0000_0040, 32'h0000_0040, "overvoltage flag kept");
    wr(A_FLAG, 32'h0000_00C0);
    wr(A_MASK, 32'h0000_0000);
    check({flag, irq}, 32'h0, "overvoltage flag cleared");
  endtask

  task automatic t_wd;
    int nd, nm, ns, nr;
    logic [1:0] rs;
    nd = 0;
    nm = 0;
    ns = 0;
    nr = 0;
    rs = 2'h0;
    @(posedge clk);
    cur_state <= 2'h2;
    set_ev(0, 1'b1);
    fork
      repeat (400)
      begin
        @(posedge clk);
        #1;
        nd += int'(!drv_en);
        nm += int'(!mrst_n);
        ns += int'(!srst_n);
        if (trg[6] === 1'b1)
        begin
          nr++;
          rs = res_state;
        end
      end
      begin
        wait_trg(0);
        rdc(A_FLAG, 32'h0000_0001, 32'h0000_0000, "timeout flag hidden in warm reset");
      end
    join
    check(nd, 250, "driver enable low span");
    check(nm, 250, "mcu reset low span");
    check(ns, 250, "soc reset low span");
    check(nr, 1, "resume once");
    check(rs, 2, "resume to prior state");
    set_ev(0, 1'b0);
    rdc(A_FLAG, 32'h0000_0001, 32'h0000_0001, "timeout flag shown");
    wr(A_FLAG, 32'h0000_0001);
    rdc(A_FLAG, 32'hFFFF_FFFF, 32'h0000_0000, "timeout flag cleared");
    // Four automatic restarts and one warm reset so far, no limit set
    rdc(32'(`OFS_STAT), 32'hFFFF_FFFF, 32'h0000_0005, "recovery count");
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_enable;
    t_seq;
    t_inst;
    t_supply;
    t_ovp;
    t_wd;
    complete_run;
  end

  // The whole sequence needs under a thousand cycles; reaching the 10000-cycle limit is a hang
  initial
  begin
    #40000;
    fails++;
    complete_run;
  end
endmodule // power_event_response_unit_test
`default_nettype wire

/* reg_access_if.sv */
// Register access strobes between bus port and register file
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  addr;
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport port (output wr_en, output rd_en, output addr, output waddr, output wdata, input rdata);
  modport regs (input wr_en, input rd_en, input addr, input waddr, input wdata, output rdata);
endinterface
`default_nettype wire
